/* File: logic/ilo_pkg.sv */
// ilo_pkg: constants shared by the indexed literal offset operand decoder
// assumes a 12-bit data address space with 256-byte banks
package ilo_pkg;
    localparam int          ADDR_W          = 12;
    localparam int          FADDR_W         = 8;
    localparam logic [7:0]  INDEX_LIMIT     = 8'h5F;
    localparam logic [7:0]  ACCESS_HI_BASE  = 8'h0F;
    localparam logic [11:0] FRAME_PTR_RST   = 12'h000;
    localparam logic [3:0]  BANK_RST        = 4'h0;
    localparam logic [7:0]  WREG_RST        = 8'h00;
    // flag vector positions: {neg, ovf, zero, dc, carry}
    localparam int          FLAG_C          = 0;
    localparam int          FLAG_DC         = 1;
    localparam int          FLAG_Z          = 2;
    localparam int          FLAG_OV         = 3;
    localparam int          FLAG_N          = 4;
    localparam logic [4:0]  FLAGS_RST       = 5'h00;
    // instruction class codes
    localparam logic [1:0]  CLS_NONE        = 2'h0;
    localparam logic [1:0]  CLS_BYTE        = 2'h1;
    localparam logic [1:0]  CLS_BIT         = 2'h2;
    // opcode patterns, top bits of the 16-bit word
    localparam logic [5:0]  OP_ADD_W_F      = 6'h09;
    localparam logic [3:0]  OP_BIT_SET      = 4'h8;
endpackage : ilo_pkg

/* File: logic/ilo_addr_map.sv */
// ilo_addr_map: combinational operand address map
// assumes inputs are stable in the cycle the address is used
`timescale 1ns/1ns
`default_nettype none
module ilo_addr_map #(
    parameter int ADDR_W = 12
) (
    // control
    input  wire logic              ext_enable,
    input  wire logic              access_sel,
    // operand sources
    input  wire logic [7:0]        file_addr,
    input  wire logic [ADDR_W-1:0] frame_ptr,
    input  wire logic [3:0]        bank,
    // result
    output logic      [ADDR_W-1:0] addr,
    output logic                   indexed
);
    always_comb begin
        // [RULE3] frame relative use
        indexed = ext_enable && !access_sel && (file_addr <= ilo_pkg::INDEX_LIMIT);
        if (indexed) begin
            // [RULE6] plain sum, zero pointer gives identity
            addr = frame_ptr + {{(ADDR_W-8){1'b0}}, file_addr};
        end else if (access_sel) begin
            // [RULE2] bank selected location
            addr = {bank, file_addr};
        end else if (file_addr > ilo_pkg::ACCESS_HI_BASE + 8'h50) begin
            // [RULE4] access addresses above 5Fh map to top bank
            addr = {4'hF, file_addr};
        end else begin
            addr = {4'h0, file_addr};
        end
    end
endmodule : ilo_addr_map
`default_nettype wire

/* File: logic/ilo_decode.sv */
// What this block does
// [RULE1] Enabling the extension also turns on indexed literal offset addressing.
// [RULE2] With the extension off, the file address is absolute in access or selected bank.
// [RULE3] With the extension on and access bit 0, an address up to 5Fh is added to the frame pointer.
// [RULE4] Addresses above 5Fh with access bit 0 keep normal access-bank decoding.
// [RULE5] The substitution applies to every byte and bit instruction with an access bit.
// [RULE6] A zero frame pointer maps 00h to 5Fh onto the original access locations.
// [RULE7] The destination bit keeps selecting working register or file in indexed mode.
// [RULE8] With the extension on, low access addresses hit frame relative locations.
// [RULE9] A configuration fuse, cleared meaning off, enables the extension.
// [RULE10] The indexed bit set sets bit b at frame pointer plus offset in one cycle.
// [RULE11] The indexed add adds W to frame pointer plus offset, sets N OV C DC Z, one cycle.
// ilo_decode: operand decode and a small byte/bit executor for the core
// assumes a single-cycle data memory with combinational read data
`timescale 1ns/1ns
`default_nettype none
module ilo_decode #(
    parameter int ADDR_W = ilo_pkg::ADDR_W
) (
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              arst_n,
    input  wire logic              clk_en,
    // configuration
    input  wire logic              extension_enable_fuse,
    // instruction
    input  wire logic              instr_valid,
    input  wire logic [15:0]       instr_word,
    // pointer and bank writes from the core
    input  wire logic              frame_ptr_we,
    input  wire logic [ADDR_W-1:0] frame_ptr_wdata,
    input  wire logic              bank_we,
    input  wire logic [3:0]        bank_wdata,
    // data memory read
    input  wire logic [7:0]        mem_rdata,
    output logic      [ADDR_W-1:0] mem_raddr,
    // data memory write
    output logic                   mem_we,
    output logic      [ADDR_W-1:0] mem_waddr,
    output logic      [7:0]        mem_wdata,
    // state
    output logic      [7:0]        wreg,
    output logic      [4:0]        flags,
    output logic                   indexed_mode,
    output logic      [ADDR_W-1:0] stack_frame_pointer,
    output logic      [3:0]        bank_selector
);
    logic              ext_q;
    logic              fuse_s1_q;
    logic [ADDR_W-1:0] fp_q;
    logic [3:0]        bank_q;
    logic [ADDR_W-1:0] addr_c;
    logic              idx_c;
    logic [1:0]        cls_c;
    logic              is_add;
    logic              is_bset;
    logic [8:0]        sum9;
    logic [4:0]        nib5;
    logic [7:0]        sum8;

    function automatic logic [1:0] instr_class(input logic [15:0] w);
        // byte ops 0x1000-0x5FFF and 0x6000-0x6FFF, bit ops 0x7000-0xBFFF
        if (w[15:12] >= 4'h7 && w[15:12] <= 4'hB) instr_class = ilo_pkg::CLS_BIT;
        else if (w[15:12] >= 4'h1 && w[15:12] <= 4'h6) instr_class = ilo_pkg::CLS_BYTE;
        else instr_class = ilo_pkg::CLS_NONE;
    endfunction : instr_class

    // [RULE9] fuse is sampled through two stages
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            fuse_s1_q <= 1'b0;
            ext_q     <= 1'b0;
        end else if (clk_en) begin
            fuse_s1_q <= extension_enable_fuse;
            ext_q     <= fuse_s1_q;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            fp_q   <= ilo_pkg::FRAME_PTR_RST;
            bank_q <= ilo_pkg::BANK_RST;
        end else if (clk_en) begin
            if (frame_ptr_we) fp_q <= frame_ptr_wdata;
            if (bank_we) bank_q <= bank_wdata;
        end
    end

    assign cls_c   = instr_class(instr_word);
    assign is_add  = instr_word[15:10] == ilo_pkg::OP_ADD_W_F;
    assign is_bset = instr_word[15:12] == ilo_pkg::OP_BIT_SET;

    // [RULE1] [RULE5] [RULE8] any class with an access bit goes through the map
    ilo_addr_map #(.ADDR_W(ADDR_W)) u_map (
        .ext_enable (ext_q && cls_c != ilo_pkg::CLS_NONE),
        .access_sel (instr_word[8]),
        .file_addr  (instr_word[7:0]),
        .frame_ptr  (fp_q),
        .bank       (bank_q),
        .addr       (addr_c),
        .indexed    (idx_c)
    );

    assign sum9 = {1'b0, wreg} + {1'b0, mem_rdata};
    assign nib5 = {1'b0, wreg[3:0]} + {1'b0, mem_rdata[3:0]};
    assign sum8 = sum9[7:0];

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            mem_raddr    <= '0;
            indexed_mode <= 1'b0;
        end else if (clk_en) begin
            mem_raddr    <= addr_c;
            indexed_mode <= instr_valid && idx_c;
        end
    end

    // [RULE10] [RULE11] single-cycle execute, write result the same edge
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            mem_we    <= 1'b0;
            mem_waddr <= '0;
            mem_wdata <= 8'h00;
            wreg      <= ilo_pkg::WREG_RST;
            flags     <= ilo_pkg::FLAGS_RST;
        end else if (clk_en) begin
            mem_we <= 1'b0;
            if (instr_valid && is_add) begin
                flags[ilo_pkg::FLAG_C]  <= sum9[8];
                flags[ilo_pkg::FLAG_DC] <= nib5[4];
                flags[ilo_pkg::FLAG_Z]  <= sum8 == 8'h00;
                flags[ilo_pkg::FLAG_OV] <= (wreg[7] == mem_rdata[7]) && (sum8[7] != wreg[7]);
                flags[ilo_pkg::FLAG_N]  <= sum8[7];
                // [RULE7] destination bit picks W or file
                if (instr_word[9]) begin
                    mem_we    <= 1'b1;
                    mem_waddr <= addr_c;
                    mem_wdata <= sum8;
                end else begin
                    wreg <= sum8;
                end
            end else if (instr_valid && is_bset) begin
                mem_we    <= 1'b1;
                mem_waddr <= addr_c;
                mem_wdata <= mem_rdata | (8'h01 << instr_word[11:9]);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            stack_frame_pointer <= ilo_pkg::FRAME_PTR_RST;
            bank_selector       <= ilo_pkg::BANK_RST;
        end else if (clk_en) begin
            stack_frame_pointer <= fp_q;
            bank_selector       <= bank_q;
        end
    end

    // [RULE3] indexed address is frame pointer plus offset
    property p_idx_addr;
        @(posedge ref_clk) disable iff (!arst_n)
        (clk_en && instr_valid && ext_q && !instr_word[8] && instr_word[7:0] <= 8'h5F
         && cls_c != ilo_pkg::CLS_NONE)
        |=> mem_raddr == $past(fp_q) + {4'h0, $past(instr_word[7:0])};
    endproperty
    a_idx_addr: assert property (p_idx_addr) else $error("indexed address wrong"); // [RULE3]

    property p_legacy_off;
        @(posedge ref_clk) disable iff (!arst_n)
        (clk_en && !ext_q) |=> !indexed_mode;
    endproperty
    a_legacy_off: assert property (p_legacy_off) else $error("indexed while disabled"); // [RULE2]

    property p_high_access;
        @(posedge ref_clk) disable iff (!arst_n)
        (clk_en && instr_valid && !instr_word[8] && instr_word[7:0] > 8'h5F)
        |=> !indexed_mode;
    endproperty
    a_high_access: assert property (p_high_access) else $error("high address indexed"); // [RULE4]

    property p_bank_sel;
        @(posedge ref_clk) disable iff (!arst_n)
        (clk_en && instr_word[8] && cls_c != ilo_pkg::CLS_NONE)
        |=> mem_raddr == {$past(bank_q), $past(instr_word[7:0])};
    endproperty
    a_bank_sel: assert property (p_bank_sel) else $error("bank address wrong"); // [RULE2]

    property p_add_dest;
        @(posedge ref_clk) disable iff (!arst_n)
        (clk_en && instr_valid && is_add) |=> mem_we == $past(instr_word[9]);
    endproperty
    a_add_dest: assert property (p_add_dest) else $error("add destination wrong"); // [RULE7]

    property p_add_sum;
        @(posedge ref_clk) disable iff (!arst_n)
        (clk_en && instr_valid && is_add && !instr_word[9])
        |=> wreg == 8'($past(wreg) + $past(mem_rdata)) && flags[ilo_pkg::FLAG_Z] == (wreg == 8'h00);
    endproperty
    a_add_sum: assert property (p_add_sum) else $error("add result wrong"); // [RULE11]

    property p_bset;
        @(posedge ref_clk) disable iff (!arst_n)
        (clk_en && instr_valid && is_bset)
        |=> mem_we && mem_wdata[$past(instr_word[11:9])] && mem_waddr == $past(addr_c)
            && (mem_wdata & $past(mem_rdata)) == $past(mem_rdata)
            && $countones(mem_wdata ^ $past(mem_rdata)) <= 1;
    endproperty
    a_bset: assert property (p_bset) else $error("bit set wrong"); // [RULE10]

    property p_fuse;
        @(posedge ref_clk) disable iff (!arst_n)
        (clk_en && !fuse_s1_q) |=> !ext_q;
    endproperty
    a_fuse: assert property (p_fuse) else $error("extension on without fuse"); // [RULE9]

    // [RULE2] absolute access bank while disabled
    property p_legacy_addr;
        @(posedge ref_clk) disable iff (!arst_n)
        (clk_en && !ext_q && !instr_word[8])
        |=> mem_raddr[7:0] == $past(instr_word[7:0])
            && mem_raddr[ADDR_W-1:8] == (($past(instr_word[7:0]) > ilo_pkg::INDEX_LIMIT) ? '1 : '0);
    endproperty
    a_legacy_addr: assert property (p_legacy_addr) else $error("access bank address wrong"); // [RULE2]
endmodule : ilo_decode
`default_nettype wire

/* File: test/tb_top.sv */
// tb_top: self-checking bench for the indexed literal offset decoder
// assumes data memory is modelled here; clk_en is high outside the freeze test
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    localparam int AW = ilo_pkg::ADDR_W;
    logic              ref_clk, arst_n, fuse, iv, fp_we, bk_we, we, idx, ce;
    logic [15:0]       iw;
    logic [AW-1:0]     fp_wd, raddr, waddr, sfp;
    logic [3:0]        bk_wd, bsel;
    logic [7:0]        rdat, wdata, wreg;
    logic [4:0]        flags;
    int                n_errors, n_tests, cyc, m_fp, m_bank, m_w, m_flags, m_ext;

    ilo_decode #(.ADDR_W(AW)) ilo_decode_inst (
        .ref_clk(ref_clk), .arst_n(arst_n), .clk_en(ce), .extension_enable_fuse(fuse),
        .instr_valid(iv), .instr_word(iw), .frame_ptr_we(fp_we), .frame_ptr_wdata(fp_wd),
        .bank_we(bk_we), .bank_wdata(bk_wd), .mem_rdata(rdat), .mem_raddr(raddr),
        .mem_we(we), .mem_waddr(waddr), .mem_wdata(wdata), .wreg(wreg), .flags(flags),
        .indexed_mode(idx), .stack_frame_pointer(sfp), .bank_selector(bsel));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : stop_test

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc >= 4000) begin
            n_errors++;
            stop_test();
        end
    end

    task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : cmp_val

    task automatic cmp_bit(input logic got, input logic exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask : cmp_bit

    // load frame pointer and bank, then check the visible copies
    task automatic ld(input int fpv, input int bkv);
        iv = 1'b0; fp_we = 1'b1; bk_we = 1'b1; fp_wd = AW'(fpv); bk_wd = 4'(bkv);
        @(negedge ref_clk);
        fp_we = 1'b0; bk_we = 1'b0; m_fp = fpv; m_bank = bkv;
        @(negedge ref_clk);
        cmp_val(16'(sfp), 16'(m_fp), "frame pointer");
        cmp_val(16'(bsel), 16'(m_bank), "bank");
    endtask : ld

    // one instruction, memory answers rd for the decoded address
    task automatic exec(input logic [15:0] w16, input logic [7:0] rd);
        int f, ix, ad, s, ov, ewe, ewd, cl;
        f = w16[7:0];
        // byte and bit instructions carry the access bit
        cl = w16[15:12] >= 1 && w16[15:12] <= 11;
        ix = m_ext && cl && !w16[8] && f <= ilo_pkg::INDEX_LIMIT;
        ad = ix ? (m_fp + f) % (1 << AW) : w16[8] ? m_bank * 256 + f
           : (f > ilo_pkg::INDEX_LIMIT ? 'hF00 + f : f);
        ewe = 0; ewd = 0;
        if (w16[15:10] == ilo_pkg::OP_ADD_W_F) begin
            s = m_w + rd;
            ov = ((m_w ^ rd) & 128) == 0 && ((m_w ^ s) & 128) != 0;
            m_flags = (((s >> 7) & 1) << 4) | (ov << 3) | (((s & 255) == 0) << 2)
                    | ((((m_w % 16) + (rd % 16)) > 15) << 1) | ((s >> 8) & 1);
            if (w16[9]) begin ewe = 1; ewd = s & 255; end
            else m_w = s & 255;
        end else if (w16[15:12] == ilo_pkg::OP_BIT_SET) begin
            ewe = 1; ewd = rd | (1 << w16[11:9]);
        end
        iv = 1'b1; iw = w16; rdat = rd;
        @(negedge ref_clk);
        cmp_val(16'(raddr), 16'(ad), "operand address");
        cmp_bit(idx, 1'(ix), "indexed mode");
        cmp_bit(we, 1'(ewe), "write strobe");
        if (ewe) cmp_val(16'(waddr), 16'(ad), "write address");
        if (ewe) cmp_val(16'(wdata), 16'(ewd), "write data");
        cmp_val(16'(wreg), 16'(m_w), "working register");
        cmp_val(16'(flags), 16'(m_flags), "flags");
    endtask : exec

    function automatic logic [15:0] rnd_op();
        logic [7:0] f;
        logic [2:0] k;
        f = ($urandom % 2) ? 8'(8'h50 + $urandom % 32) : 8'($urandom);
        k = 3'($urandom);
        case ($urandom % 5)
            0: rnd_op = {ilo_pkg::OP_ADD_W_F, k[1:0], f};
            1: rnd_op = {ilo_pkg::OP_BIT_SET, k, 1'($urandom), f};
            2: rnd_op = {4'h5, 4'($urandom), f};
            3: rnd_op = {4'h9, 4'($urandom), f};
            // no access bit: never indexed
            default: rnd_op = {4'hE, 4'($urandom), f};
        endcase
    endfunction : rnd_op

    task automatic rnd_run(input int n);
        for (int i = 0; i < n; i++) begin
            if (i % 25 == 0) ld($urandom % (1 << AW), $urandom % 16);
            exec(rnd_op(), 8'($urandom));
        end
    endtask : rnd_run

    initial begin
        arst_n = 1'b0; fuse = 1'b0; iv = 1'b0; fp_we = 1'b0; bk_we = 1'b0; ce = 1'b1;
        iw = 16'h0000; fp_wd = '0; bk_wd = 4'h0; rdat = 8'h00;
        m_fp = 0; m_bank = 0; m_w = 0; m_flags = 0; m_ext = 0;
        void'($urandom(61));
        repeat (16) @(negedge ref_clk);
        cmp_val({raddr, bsel}, 16'h0000, "reset address and bank");
        cmp_val({wreg, 3'b000, flags}, 16'h0000, "reset data state");
        cmp_bit(we | idx | (|sfp), 1'b0, "reset strobes");
        arst_n = 1'b1;
        $display("test reset finished");
        // fuse cleared: everything absolute
        rnd_run(60);
        $display("test legacy finished");
        fuse = 1'b1; iv = 1'b0;
        repeat (3) @(negedge ref_clk);
        m_ext = 1;
        ld('h0A00, 3);
        exec(16'h2500, 8'h17);
        exec(16'h242C, 8'h20);
        exec(16'h262C, 8'h20);
        exec(16'h8E0A, 8'h55);
        exec(16'h805F, 8'h00);
        exec(16'h8060, 8'h00);
        exec(16'h8120, 8'h00);
        ld('h0FF0, 0);
        exec(16'h245F, 8'hFF);
        ld(0, 0);
        exec(16'h2420, 8'h80);
        $display("test directed finished");
        // clock enable low: nothing moves, fuse stages included
        ce = 1'b0;
        fuse = 1'b0;
        fp_we = 1'b1;
        fp_wd = '1;
        iv = 1'b1;
        iw = 16'h2620;
        repeat (3) @(negedge ref_clk);
        cmp_val(16'(sfp), 16'(m_fp), "frozen frame pointer");
        cmp_val({wreg, 3'b000, flags}, {8'(m_w), 3'b000, 5'(m_flags)}, "frozen state");
        cmp_bit(idx, 1'b1, "frozen indexed mode");
        ce = 1'b1;
        fuse = 1'b1;
        fp_we = 1'b0;
        $display("test freeze finished");
        rnd_run(300);
        $display("test random finished");
        iv = 1'b0;
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
